// ### bench/cps_panel_model.sv
// front-panel model: register bus master and pattern entry for the engine
`timescale 1ns/1ps
module cps_panel_model (
  input wire logic clk_sys_i,
  input wire logic [31:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // bus idle from time zero
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 32'h00000000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // one-cycle write; data lines scrambled once the strobe is gone
  task automatic write_reg(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~data;
  endtask : write_reg

  // one-cycle read; data stands only in the following cycle
  task automatic read_reg(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= addr;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    #1;
    data = reg_rdata_i;
  endtask : read_reg

  // keypad digits 1, 0 or X, most significant first, become value and mask
  task automatic enter_pattern(input string digits);
    logic [31:0] pat;
    logic [31:0] care;
    int idx;
    pat = 32'h00000000;
    care = 32'h00000000;
    for (int i = 0; i < digits.len(); i++)
    begin
      idx = digits.len() - 1 - i;
      if (digits[i] != "X")
      begin
        care[idx] = 1'b1;
        pat[idx] = (digits[i] == "1");
      end
    end
    write_reg(cps_pkg::REG_PATTERN, pat);
    write_reg(cps_pkg::REG_CARE, care);
  endtask : enter_pattern
endmodule : cps_panel_model

// ### bench/test_capture_pattern_search.sv
// self-checking bench of the capture pattern search engine
`timescale 1ns/1ps
module test_capture_pattern_search;
  logic clk_sys_i;
  logic rst_n_i;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic cap_wr;
  logic cap_ref;
  logic [9:0] cap_addr;
  logic [31:0] cap_data;
  logic busy;
  logic result_valid;
  logic [9:0] cursor;
  logic [10:0] count;
  logic [31:0] st;
  int mismatches = 0;
  int check_count = 0;

  cps_search i_cps_search (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .cap_wr_i(cap_wr),
    .cap_ref_i(cap_ref), .cap_addr_i(cap_addr), .cap_data_i(cap_data),
    .busy_o(busy), .result_valid_o(result_valid), .cursor_o(cursor),
    .count_o(count));
  cps_panel_model i_panel (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd));

  // 100 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // recording: run 5..7 and single hit 20 in group A&B, one C&D hit at 100
  function automatic logic [31:0] src_word(input int a);
    if ((a >= 5 && a <= 7) || a == 20)
      return 32'h000000A5;
    if (a == 100)
      return 32'h00A50000;
    return 32'h00000000;
  endfunction : src_word

  // reference differs from source at 3, 4 and 50
  function automatic logic [31:0] ref_word(input int a);
    if (a == 3 || a == 4)
      return 32'h00000011;
    if (a == 50)
      return 32'h000000A5;
    return src_word(a);
  endfunction : ref_word

  // every location is written, since the memories come up unknown
  task automatic fill;
    for (int a = 0; a < 2048; a++)
    begin
      @(posedge clk_sys_i);
      cap_wr <= 1'b1;
      cap_ref <= (a >= 1024);
      cap_addr <= a[9:0];
      cap_data <= (a >= 1024) ? ref_word(a - 1024) : src_word(a);
    end
    @(posedge clk_sys_i);
    cap_wr <= 1'b0;
  endtask : fill

  // bounded wait for the engine to settle in ready
  task automatic wait_done;
    int n;
    n = 0;
    #1;
    while (result_valid !== 1'b1 && n < 1200)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check("ready in time", 32'h1, 32'(result_valid));
  endtask : wait_done

  // execute, then compare count, cursor when a nonzero count is expected, and fetch status
  task automatic run(input logic [10:0] cnt, input logic [9:0] cur);
    i_panel.write_reg(cps_pkg::REG_CMD, 32'h00000001);
    #1;
    check("busy", 32'h1, 32'(busy));
    wait_done();
    check("count", 32'(cnt), 32'(count));
    if (cnt != 11'h000)
      check("cursor", 32'(cur), 32'(cursor));
    i_panel.read_reg(cps_pkg::REG_STATUS, st);
  endtask : run

  task automatic t_no_pattern;
    i_panel.read_reg(cps_pkg::REG_CTRL, st);
    check("ctrl reset", 32'h0, st);
    i_panel.read_reg(8'hFC, st);
    check("unmapped read", 32'h0, st);
    i_panel.write_reg(cps_pkg::REG_CMD, 32'h00000001);
    repeat (3) @(posedge clk_sys_i);
    #1;
    check("busy no pattern", 32'h0, 32'(busy));
    check("valid no pattern", 32'h0, 32'(result_valid));
    $display("test no_pattern done");
  endtask : t_no_pattern

  task automatic t_source_word;
    i_panel.enter_pattern("10100101");
    run(11'd4, 10'd5);
    check("run start", 32'h1, 32'(st[4]));
    run(11'd4, 10'd7);
    check("run end", 32'h1, 32'(st[5]));
    run(11'd4, 10'd20);
    run(11'd4, 10'd20);
    check("last reached", 32'h1, 32'(st[7]));
    $display("test source_word done");
  endtask : t_source_word

  task automatic t_reference;
    i_panel.write_reg(cps_pkg::REG_CTRL, 32'h00000008);
    i_panel.write_reg(cps_pkg::REG_CMD, 32'h00000001);
    #1;
    check("count cleared", 32'h0, 32'(count));
    wait_done();
    check("ref count", 32'd5, 32'(count));
    check("ref cursor", 32'd5, 32'(cursor));
    run(11'd5, 10'd7);
    $display("test reference done");
  endtask : t_reference

  task automatic t_timing;
    // a reference request in timing view still searches source
    i_panel.write_reg(cps_pkg::REG_CTRL, 32'h0000000C);
    run(11'd4, 10'd5);
    check("ref refused", 32'h1, 32'(st[6]));
    i_panel.write_reg(cps_pkg::REG_PATTERN, 32'h00A500A5);
    i_panel.write_reg(cps_pkg::REG_CARE, 32'hFFFFFFFF);
    i_panel.write_reg(cps_pkg::REG_CTRL, 32'h00000014);
    run(11'd1, 10'd100);
    i_panel.write_reg(cps_pkg::REG_CTRL, 32'h00000004);
    run(11'd4, 10'd5);
    $display("test timing done");
  endtask : t_timing

  task automatic t_dont_care;
    i_panel.write_reg(cps_pkg::REG_CTRL, 32'h00000000);
    i_panel.enter_pattern("1010010X");
    run(11'd4, 10'd5);
    i_panel.enter_pattern("10100100");
    run(11'd0, 10'd0);
    $display("test dont_care done");
  endtask : t_dont_care

  task automatic t_compare;
    i_panel.write_reg(cps_pkg::REG_CTRL, 32'h00000002);
    run(11'd3, 10'd3);
    run(11'd3, 10'd4);
    i_panel.write_reg(cps_pkg::REG_CTRL, 32'h00000001);
    run(11'd1021, 10'd0);
    $display("test compare done");
  endtask : t_compare

  // main sequence: reset, no-pattern scenario, load recordings, remaining scenarios
  initial
  begin
    rst_n_i = 1'b0;
    cap_wr = 1'b0;
    cap_ref = 1'b0;
    cap_addr = 10'h000;
    cap_data = 32'h00000000;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_no_pattern();
    fill();
    t_source_word();
    t_reference();
    t_timing();
    t_dont_care();
    t_compare();
    wrap_up();
  end

  // hang guard: about six times the expected run length
  initial
  begin
    repeat (80000) @(posedge clk_sys_i);
    mismatches++;
    wrap_up();
  end
endmodule : test_capture_pattern_search

// ### verilog/cps_capture_mem.sv
// one capture memory with a registered read port
`timescale 1ns/1ps
module cps_capture_mem (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [cps_pkg::AW-1:0] wr_addr_i,
  input wire logic [cps_pkg::DW-1:0] wr_data_i,
  input wire logic [cps_pkg::AW-1:0] rd_addr_i,
  output logic [cps_pkg::DW-1:0] rd_data_o
);
  logic [cps_pkg::DW-1:0] mem_array [0:(1 << cps_pkg::AW)-1];

  // array has no reset so it maps onto block ram
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem_array[wr_addr_i] <= wr_data_i;
    end
  end

  // read data one cycle after the address
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= '0;
    end
    else
    begin
      rd_data_o <= mem_array[rd_addr_i];
    end
  end
endmodule : cps_capture_mem

// ### verilog/cps_pkg.sv
// shared constants and types of the capture pattern search block
package cps_pkg;
  // capture memory geometry
  localparam int DW = 32;
  localparam int AW = 10;
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] LAST_ADDR = 11'h3FF;
  localparam logic [CW-1:0] END_ADDR = 11'h400;
  localparam logic [CW-1:0] COUNT_ONE = 11'h001;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PATTERN = 8'h04;
  localparam logic [7:0] REG_CARE = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;
  localparam logic [7:0] REG_CURSOR = 8'h18;
  // control fields
  localparam int CTRL_W = 5;
  localparam int CTRL_KIND_LSB = 0;
  localparam int CTRL_VIEW_BIT = 2;
  localparam int CTRL_MEM_BIT = 3;
  localparam int CTRL_PAIR_BIT = 4;
  localparam logic [1:0] KIND_WORD = 2'h0;
  localparam logic [1:0] KIND_EQUAL = 2'h1;
  localparam logic [1:0] KIND_UNEQUAL = 2'h2;
  localparam int CMD_EXEC_BIT = 0;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [DW-1:0] PATTERN_RST = 32'h00000000;
  localparam logic [DW-1:0] CARE_RST = 32'h00000000;
  // channel-group pair masks for timing view
  localparam logic [DW-1:0] PAIR_AB_MASK = 32'h0000FFFF;
  localparam logic [DW-1:0] PAIR_CD_MASK = 32'hFFFF0000;
  typedef enum logic [1:0] {
    CPS_IDLE,
    CPS_SCAN,
    CPS_READY,
    CPS_STEP
  } cps_state_e;
endpackage : cps_pkg

// ### verilog/cps_search.sv
// pattern and compare search engine over source and reference capture
`timescale 1ns/1ps
module cps_search (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [cps_pkg::DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [cps_pkg::DW-1:0] reg_rdata_o,
  input wire logic cap_wr_i,
  input wire logic cap_ref_i,
  input wire logic [cps_pkg::AW-1:0] cap_addr_i,
  input wire logic [cps_pkg::DW-1:0] cap_data_i,
  output logic busy_o,
  output logic result_valid_o,
  output logic [cps_pkg::AW-1:0] cursor_o,
  output logic [cps_pkg::CW-1:0] count_o
);
  cps_pkg::cps_state_e state_reg;
  logic [cps_pkg::CTRL_W-1:0] ctrl_reg;
  logic [cps_pkg::DW-1:0] pattern_reg;
  logic [cps_pkg::DW-1:0] care_reg;
  logic pat_entered_reg;
  logic [cps_pkg::CW-1:0] iss_addr_reg;
  logic [cps_pkg::CW-1:0] dat_addr_reg;
  logic val_reg;
  logic [cps_pkg::CW-1:0] count_reg;
  logic [cps_pkg::AW-1:0] cursor_reg;
  logic found_reg;
  logic run_start_reg;
  logic run_end_reg;
  logic end_pend_reg;
  logic last_reg;
  logic wprev_reg;
  logic wcur_reg;
  logic wcur_ok_reg;
  logic [cps_pkg::CW-1:0] waddr_reg;
  logic wr_ctrl, wr_pat, wr_care, wr_cmd, settings_wr;
  logic [cps_pkg::DW-1:0] rd_value;
  logic [cps_pkg::DW-1:0] src_q, ref_q, sel_q, eff_care, status_w;
  logic [1:0] kind;
  logic view_tim, sel_ref, exec_cmd, start_ok, step_ok;
  logic in_run, hit_now, stop, step_end, scan_end;

  // a location hits when every cared bit agrees, or per compare mode
  function automatic logic cps_hit(
    input logic [1:0] k,
    input logic [cps_pkg::DW-1:0] data,
    input logic [cps_pkg::DW-1:0] src,
    input logic [cps_pkg::DW-1:0] refd,
    input logic [cps_pkg::DW-1:0] pat,
    input logic [cps_pkg::DW-1:0] care
  );
    logic h;
    h = 1'b0;
    case (k)
      cps_pkg::KIND_WORD: h = (((data ^ pat) & care) == '0);
      cps_pkg::KIND_EQUAL: h = (src == refd);
      cps_pkg::KIND_UNEQUAL: h = (src != refd);
      default: h = 1'b0;
    endcase
    return h;
  endfunction : cps_hit

  // register address decode
  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_pat = 1'b0;
    wr_care = 1'b0;
    wr_cmd = 1'b0;
    rd_value = '0;
    if (reg_addr_i == cps_pkg::REG_CTRL)
    begin
      wr_ctrl = reg_wr_i;
      rd_value = {27'h0000000, ctrl_reg};
    end
    else if (reg_addr_i == cps_pkg::REG_PATTERN)
    begin
      wr_pat = reg_wr_i;
      rd_value = pattern_reg;
    end
    else if (reg_addr_i == cps_pkg::REG_CARE)
    begin
      wr_care = reg_wr_i;
      rd_value = care_reg;
    end
    else if (reg_addr_i == cps_pkg::REG_CMD)
    begin
      wr_cmd = reg_wr_i;
    end
    else if (reg_addr_i == cps_pkg::REG_STATUS)
    begin
      rd_value = status_w;
    end
    else if (reg_addr_i == cps_pkg::REG_COUNT)
    begin
      rd_value = {21'h000000, count_reg};
    end
    else if (reg_addr_i == cps_pkg::REG_CURSOR)
    begin
      rd_value = {22'h000000, cursor_reg};
    end
  end

  assign settings_wr = wr_ctrl | wr_pat | wr_care;
  assign status_w = {24'h000000, last_reg,
    sel_ref ^ ctrl_reg[cps_pkg::CTRL_MEM_BIT],
    run_end_reg, run_start_reg, found_reg, pat_entered_reg,
    result_valid_o, busy_o};

  // mode decode: timing view forces source and masks to the pair
  assign kind = ctrl_reg[cps_pkg::CTRL_KIND_LSB +: 2];
  assign view_tim = ctrl_reg[cps_pkg::CTRL_VIEW_BIT];
  assign sel_ref = ctrl_reg[cps_pkg::CTRL_MEM_BIT] & ~view_tim;
  assign eff_care = !view_tim ? care_reg :
    care_reg & (ctrl_reg[cps_pkg::CTRL_PAIR_BIT] ?
    cps_pkg::PAIR_CD_MASK : cps_pkg::PAIR_AB_MASK);
  assign sel_q = sel_ref ? ref_q : src_q;
  assign hit_now = val_reg && !dat_addr_reg[cps_pkg::AW] &&
    cps_hit(kind, sel_q, src_q, ref_q, pattern_reg, eff_care);

  // execute starts a word scan only once a pattern exists; compare scans need none
  assign exec_cmd = wr_cmd & reg_wdata_i[cps_pkg::CMD_EXEC_BIT];
  assign start_ok = exec_cmd && state_reg == cps_pkg::CPS_IDLE &&
    (kind != cps_pkg::KIND_WORD || pat_entered_reg);
  assign step_ok = exec_cmd && state_reg == cps_pkg::CPS_READY &&
    found_reg;
  assign in_run = state_reg == cps_pkg::CPS_SCAN ||
    state_reg == cps_pkg::CPS_STEP;
  assign scan_end = state_reg == cps_pkg::CPS_SCAN && val_reg &&
    dat_addr_reg == cps_pkg::LAST_ADDR;
  // a run edge: hit with a miss before or after it
  assign stop = state_reg == cps_pkg::CPS_STEP && val_reg && wcur_ok_reg &&
    waddr_reg > {1'b0, cursor_reg} && wcur_reg &&
    (!wprev_reg || !hit_now);
  assign step_end = state_reg == cps_pkg::CPS_STEP && val_reg &&
    dat_addr_reg == cps_pkg::END_ADDR && !stop;

  assign busy_o = in_run;
  assign result_valid_o = state_reg == cps_pkg::CPS_READY;
  assign cursor_o = cursor_reg;
  assign count_o = count_reg;

  cps_capture_mem u_source_capture_memory (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(cap_wr_i & ~cap_ref_i),
    .wr_addr_i(cap_addr_i),
    .wr_data_i(cap_data_i),
    .rd_addr_i(iss_addr_reg[cps_pkg::AW-1:0]),
    .rd_data_o(src_q)
  );

  cps_capture_mem u_reference_memory (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(cap_wr_i & cap_ref_i),
    .wr_addr_i(cap_addr_i),
    .wr_data_i(cap_data_i),
    .rd_addr_i(iss_addr_reg[cps_pkg::AW-1:0]),
    .rd_data_o(ref_q)
  );

  // software settings; a three-state bit is pattern plus care
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg <= cps_pkg::CTRL_RST;
      pattern_reg <= cps_pkg::PATTERN_RST;
      care_reg <= cps_pkg::CARE_RST;
      pat_entered_reg <= 1'b0;
      reg_rdata_o <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= reg_wdata_i[cps_pkg::CTRL_W-1:0];
      if (wr_pat)
        pattern_reg <= reg_wdata_i;
      if (wr_care)
        care_reg <= reg_wdata_i;
      if (wr_pat | wr_care)
        pat_entered_reg <= 1'b1;
      reg_rdata_o <= reg_rd_i ? rd_value : '0;
    end
  end

  // sequencing; any settings change discards the old result
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= cps_pkg::CPS_IDLE;
    else if (settings_wr)
      state_reg <= cps_pkg::CPS_IDLE;
    else
    begin
      case (state_reg)
        cps_pkg::CPS_IDLE:
          if (start_ok)
            state_reg <= cps_pkg::CPS_SCAN;
        cps_pkg::CPS_SCAN:
          if (scan_end)
            state_reg <= cps_pkg::CPS_READY;
        cps_pkg::CPS_READY:
          if (step_ok)
            state_reg <= cps_pkg::CPS_STEP;
        default:
          if (stop || step_end)
            state_reg <= cps_pkg::CPS_READY;
      endcase
    end
  end

  // read pipeline: one address issued per cycle, data valid next cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      iss_addr_reg <= '0;
      dat_addr_reg <= '0;
      val_reg <= 1'b0;
    end
    else
    begin
      if (start_ok)
        iss_addr_reg <= '0;
      else if (step_ok)
        iss_addr_reg <= {1'b0, cursor_reg};
      else if (in_run && iss_addr_reg != cps_pkg::END_ADDR)
        iss_addr_reg <= iss_addr_reg + cps_pkg::COUNT_ONE;
      dat_addr_reg <= iss_addr_reg;
      val_reg <= in_run && !settings_wr && !scan_end && !stop && !step_end;
    end
  end

  // three-hit window for run-edge detection while stepping
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wprev_reg <= 1'b0;
      wcur_reg <= 1'b0;
      wcur_ok_reg <= 1'b0;
      waddr_reg <= '0;
    end
    else if (step_ok)
      wcur_ok_reg <= 1'b0;
    else if (state_reg == cps_pkg::CPS_STEP && val_reg)
    begin
      wprev_reg <= wcur_reg;
      wcur_reg <= hit_now;
      waddr_reg <= dat_addr_reg;
      wcur_ok_reg <= 1'b1;
    end
  end

  // count, cursor and run-edge flags
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_reg <= '0;
      cursor_reg <= '0;
      found_reg <= 1'b0;
      run_start_reg <= 1'b0;
      run_end_reg <= 1'b0;
      end_pend_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else if (start_ok)
    begin
      count_reg <= '0;
      found_reg <= 1'b0;
      run_start_reg <= 1'b0;
      run_end_reg <= 1'b0;
      end_pend_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else if (state_reg == cps_pkg::CPS_SCAN && val_reg)
    begin
      if (hit_now)
        count_reg <= count_reg + cps_pkg::COUNT_ONE;
      if (hit_now && !found_reg)
      begin
        cursor_reg <= dat_addr_reg[cps_pkg::AW-1:0];
        found_reg <= 1'b1;
        run_start_reg <= 1'b1;
        run_end_reg <= dat_addr_reg == cps_pkg::LAST_ADDR;
        end_pend_reg <= dat_addr_reg != cps_pkg::LAST_ADDR;
      end
      else if (end_pend_reg)
      begin
        run_end_reg <= !hit_now;
        end_pend_reg <= 1'b0;
      end
    end
    else if (stop)
    begin
      cursor_reg <= waddr_reg[cps_pkg::AW-1:0];
      run_start_reg <= !wprev_reg;
      run_end_reg <= !hit_now;
    end
    else if (step_end)
      last_reg <= 1'b1;
  end

  // every check below shares the system clock and the reset
  default clocking cps_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_exec_idle;
    exec_cmd && state_reg == cps_pkg::CPS_IDLE && !settings_wr;
  endsequence

  sequence s_step_hit;
    state_reg == cps_pkg::CPS_STEP && stop && !settings_wr;
  endsequence

  chk_exec_gate: assert property (
    s_exec_idle ##0 (kind == cps_pkg::KIND_WORD && !pat_entered_reg)
    |=> state_reg == cps_pkg::CPS_IDLE)
    else $error("scan began without a pattern");
  chk_scan_start: assert property (
    s_exec_idle ##0 start_ok
    |=> state_reg == cps_pkg::CPS_SCAN && count_reg == '0)
    else $error("execute did not start a cleared scan");
  chk_count_step: assert property (
    state_reg == cps_pkg::CPS_SCAN && hit_now && !settings_wr
    |=> count_reg == $past(count_reg) + cps_pkg::COUNT_ONE)
    else $error("match not counted");
  chk_first_cursor: assert property (
    state_reg == cps_pkg::CPS_SCAN && hit_now && !found_reg && !settings_wr
    |=> cursor_reg == $past(dat_addr_reg[cps_pkg::AW-1:0]) && found_reg)
    else $error("cursor not on first match");
  chk_step_fwd: assert property (
    s_step_hit |=> cursor_reg > $past(cursor_reg) &&
    state_reg == cps_pkg::CPS_READY)
    else $error("step did not advance cursor");
  chk_run_edge: assert property (
    s_step_hit |=> run_start_reg || run_end_reg)
    else $error("cursor stopped inside a run");
  chk_list_mem: assert property (
    !view_tim |-> sel_ref == ctrl_reg[cps_pkg::CTRL_MEM_BIT])
    else $error("list view searched wrong memory");
  chk_timing_src: assert property (
    view_tim |-> !sel_ref)
    else $error("timing view searched reference");
  chk_pair_mask: assert property (
    view_tim && !ctrl_reg[cps_pkg::CTRL_PAIR_BIT] |-> eff_care[31:16] == '0)
    else $error("pattern spills outside pair");
  chk_compare_hit: assert property (
    val_reg && !dat_addr_reg[cps_pkg::AW] && kind == cps_pkg::KIND_UNEQUAL
    |-> hit_now == (src_q != ref_q))
    else $error("unequal compare wrong");
  chk_dont_care: assert property (
    kind == cps_pkg::KIND_WORD && ((sel_q ^ pattern_reg) & eff_care) != '0
    |-> !hit_now)
    else $error("cared bit mismatch counted");
  chk_last_hold: assert property (
    step_end && !settings_wr |=> $stable(cursor_reg) && last_reg)
    else $error("cursor moved past last match");
endmodule : cps_search
